// [rhc_consts.vh]
/*
 runtime hours counter constants: register offsets, field positions, reset values
 and timing counts. assumes a 200 MHz pclk and a 32-bit apb register bus.
*/
`ifndef RHC_CONSTS_VH
`define RHC_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define RHC_CLK_MHZ          200
`define RHC_TICK_TIME_US     1000
`define RHC_TICK_CYCLES      (`RHC_TICK_TIME_US * `RHC_CLK_MHZ)
`define RHC_MS_PER_DAY       32'h0526_5C00
`define RHC_MS_PER_HOUR      32'h0036_EE80
`define RHC_FAN_MARGIN_H     32'h0000_01F4

// ****************************************
// register byte offsets
// ****************************************
`define RHC_OFF_CTRL         12'h000
`define RHC_OFF_STATUS       12'h004
`define RHC_OFF_TOT_MS       12'h008
`define RHC_OFF_TOT_DAYS     12'h00C
`define RHC_OFF_REL_MS       12'h010
`define RHC_OFF_MOT_HOURS    12'h014
`define RHC_OFF_MAINT_INT    12'h018
`define RHC_OFF_FAN_HOURS    12'h01C
`define RHC_OFF_FAN_LIFE     12'h020
`define RHC_OFF_MOT_HOURS_B  12'h024

// ****************************************
// field positions
// ****************************************
`define RHC_CTRL_DSET_BIT    0
`define RHC_CTRL_RESTORE_BIT 1
`define RHC_ST_MAINT_BIT     0
`define RHC_ST_FAN_BIT       1
`define RHC_ST_PULSE_BIT     2
`define RHC_ST_SAVE_BIT      3

`define RHC_RST_ZERO         32'h0000_0000

`endif

// [rhc_tick_gen.v]
/*
 one-millisecond tick prescaler.
 assumes a free-running pclk; the tick is a one-cycle enable pulse.
*/
`timescale 1ns/1ps
`include "rhc_consts.vh"

module rhc_tick_gen #(
  parameter integer TICK_CYCLES = `RHC_TICK_CYCLES
) (
  input  wire pclk,
  input  wire presetn,
  output reg  tick_ms_ff
);

  reg  [31:0] cnt_ff;
  wire        wrap = (cnt_ff == TICK_CYCLES[31:0] - 32'h0000_0001);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff     <= 32'h0000_0000;
      tick_ms_ff <= 1'b0;
    end else begin
      cnt_ff     <= wrap ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
      tick_ms_ff <= wrap;
    end
  end

endmodule // rhc_tick_gen

// [rhc_runtime.v]
/*
 runtime hours counters: total runtime (ms wrapping daily plus days), relative
 runtime since power-on, motor hours gated by pulse enable with maintenance fault,
 fan hours with end-of-life alarm. apb slave for software access.
 assumes an external non-volatile store: it presents saved values on nv_*_in and
 pulses nv_restore (or software sets the restore bit); save requests pulse out on
 nv_save_* with the values on the nv_*_out ports. power_fail and pulse_en are pins.
*/
// The placing of the registers and the APB slave port were chosen for this implementation.
// How it works
// - millisecond total runtime wraps at one day
// - day counter advances on each daily wrap
// - total runtime saved on power-down
// - total runtime resumes from saved value
// - relative milliseconds since power-on, free wrap
// - motor hours count while pulse enable active
// - pulse enable removed stops and saves count
// - zero maintenance interval disables motor counting
// - maintenance fault when hours reach interval
// - fan hours accumulate; any write clears, whatever the data
// - fan alarm within 500 hours of life
// - zero fan life disables fan alarm
`timescale 1ns/1ps
`include "rhc_consts.vh"

module rhc_runtime #(
  parameter integer TICK_CYCLES = `RHC_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        pulse_en,
  input  wire        power_fail,
  input  wire        nv_restore,
  input  wire [31:0] nv_tot_ms_in,
  input  wire [31:0] nv_tot_days_in,
  input  wire [31:0] nv_mot_a_in,
  input  wire [31:0] nv_mot_b_in,
  output reg         nv_save_total,
  output reg         nv_save_motor,
  output reg  [31:0] nv_tot_ms_out,
  output reg  [31:0] nv_tot_days_out,
  output reg  [31:0] nv_mot_out,
  output reg         maintenance_due_fault,
  output reg         fan_life_alarm
);

  // ****************************************
  // helpers
  // ****************************************
  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer      i;
    begin
      strb_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          strb_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg  [1:0] pen_sync_ff;
  reg  [1:0] pf_sync_ff;
  reg  [1:0] rst_sync_ff;
  reg        pen_d_ff;
  reg        pf_d_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_sync_ff <= 2'h0;
      pf_sync_ff  <= 2'h0;
      rst_sync_ff <= 2'h0;
      pen_d_ff    <= 1'b0;
      pf_d_ff     <= 1'b0;
    end else begin
      pen_sync_ff <= {pen_sync_ff[0], pulse_en};
      pf_sync_ff  <= {pf_sync_ff[0], power_fail};
      rst_sync_ff <= {rst_sync_ff[0], nv_restore};
      pen_d_ff    <= pen_sync_ff[1];
      pf_d_ff     <= pf_sync_ff[1];
    end
  end

  wire pen_s     = pen_sync_ff[1];
  wire pf_s      = pf_sync_ff[1];
  wire pen_fall  = pen_d_ff & ~pen_s;
  wire pf_rise   = pf_s & ~pf_d_ff;

  // ****************************************
  // millisecond tick
  // ****************************************
  wire tick_ms;

  rhc_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) i_rhc_tick_gen (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick_ms_ff (tick_ms)
  );

  // ****************************************
  // apb decode
  // ****************************************
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire hit   = is_addr(paddr, `RHC_OFF_CTRL)      | is_addr(paddr, `RHC_OFF_STATUS)    |
               is_addr(paddr, `RHC_OFF_TOT_MS)    | is_addr(paddr, `RHC_OFF_TOT_DAYS)  |
               is_addr(paddr, `RHC_OFF_REL_MS)    | is_addr(paddr, `RHC_OFF_MOT_HOURS) |
               is_addr(paddr, `RHC_OFF_MAINT_INT) | is_addr(paddr, `RHC_OFF_FAN_HOURS) |
               is_addr(paddr, `RHC_OFF_FAN_LIFE)  | is_addr(paddr, `RHC_OFF_MOT_HOURS_B);

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  wire wr_ctrl  = wr & is_addr(paddr, `RHC_OFF_CTRL);
  wire wr_tms   = wr & is_addr(paddr, `RHC_OFF_TOT_MS);
  wire wr_tdays = wr & is_addr(paddr, `RHC_OFF_TOT_DAYS);
  wire wr_mot   = wr & is_addr(paddr, `RHC_OFF_MOT_HOURS);
  wire wr_maint = wr & is_addr(paddr, `RHC_OFF_MAINT_INT);
  wire wr_fan   = wr & is_addr(paddr, `RHC_OFF_FAN_HOURS);
  wire wr_life  = wr & is_addr(paddr, `RHC_OFF_FAN_LIFE);
  wire wr_motb  = wr & is_addr(paddr, `RHC_OFF_MOT_HOURS_B);

  // ****************************************
  // registers
  // ****************************************
  reg  [1:0]  ctrl_ff;
  reg  [31:0] total_runtime_count_ff;
  reg  [31:0] total_days_ff;
  reg  [31:0] relative_runtime_count_ff;
  reg  [31:0] motor_hours_count_ff;
  reg  [31:0] motor_hours_b_ff;
  reg  [31:0] motor_ms_ff;
  reg  [31:0] maintenance_interval_ff;
  reg  [31:0] fan_hours_count_ff;
  reg  [31:0] fan_ms_ff;
  reg  [31:0] fan_service_life_ff;

  wire dset_b     = ctrl_ff[`RHC_CTRL_DSET_BIT];
  wire restore    = rst_sync_ff[1] | (wr_ctrl & pwdata[`RHC_CTRL_RESTORE_BIT]);
  wire day_wrap   = tick_ms & (total_runtime_count_ff == `RHC_MS_PER_DAY - 32'h0000_0001);
  wire mot_run    = pen_s & (maintenance_interval_ff != `RHC_RST_ZERO);
  wire mot_hour   = tick_ms & mot_run & (motor_ms_ff == `RHC_MS_PER_HOUR - 32'h0000_0001);
  wire fan_hour   = tick_ms & (fan_ms_ff == `RHC_MS_PER_HOUR - 32'h0000_0001);
  wire [31:0] mot_sel = dset_b ? motor_hours_b_ff : motor_hours_count_ff;

  // ctrl register; the restore bit self-clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 2'h0;
    end else if (wr_ctrl) begin
      ctrl_ff <= {1'b0, pwdata[`RHC_CTRL_DSET_BIT]};
    end
  end

  // total runtime: ms wraps daily, days advance on the wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_runtime_count_ff <= `RHC_RST_ZERO;
      total_days_ff          <= `RHC_RST_ZERO;
    end else if (restore) begin
      total_runtime_count_ff <= nv_tot_ms_in;
      total_days_ff          <= nv_tot_days_in;
    end else begin
      if (wr_tms) begin
        total_runtime_count_ff <= strb_merge(total_runtime_count_ff, pwdata, pstrb);
      end else if (day_wrap) begin
        total_runtime_count_ff <= `RHC_RST_ZERO;
      end else if (tick_ms) begin
        total_runtime_count_ff <= total_runtime_count_ff + 32'h0000_0001;
      end
      if (wr_tdays) begin
        total_days_ff <= strb_merge(total_days_ff, pwdata, pstrb);
      end else if (day_wrap) begin
        total_days_ff <= total_days_ff + 32'h0000_0001;
      end
    end
  end

  // relative runtime: cleared only by reset, wraps freely after about 49 days
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relative_runtime_count_ff <= `RHC_RST_ZERO;
    end else if (tick_ms) begin
      relative_runtime_count_ff <= relative_runtime_count_ff + 32'h0000_0001;
    end
  end

  // motor hours, two data sets; the active set counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_hours_count_ff <= `RHC_RST_ZERO;
      motor_hours_b_ff     <= `RHC_RST_ZERO;
      motor_ms_ff          <= `RHC_RST_ZERO;
    end else if (restore) begin
      motor_hours_count_ff <= nv_mot_a_in;
      motor_hours_b_ff     <= nv_mot_b_in;
      motor_ms_ff          <= `RHC_RST_ZERO;
    end else begin
      if (wr_mot) begin
        motor_hours_count_ff <= strb_merge(motor_hours_count_ff, pwdata, pstrb);
      end else if (mot_hour & ~dset_b) begin
        motor_hours_count_ff <= motor_hours_count_ff + 32'h0000_0001;
      end
      if (wr_motb) begin
        motor_hours_b_ff <= strb_merge(motor_hours_b_ff, pwdata, pstrb);
      end else if (mot_hour & dset_b) begin
        motor_hours_b_ff <= motor_hours_b_ff + 32'h0000_0001;
      end
      if (mot_hour | wr_mot | wr_motb) begin
        motor_ms_ff <= `RHC_RST_ZERO;
      end else if (tick_ms & mot_run) begin
        motor_ms_ff <= motor_ms_ff + 32'h0000_0001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maintenance_interval_ff <= `RHC_RST_ZERO;
      fan_service_life_ff     <= `RHC_RST_ZERO;
    end else begin
      if (wr_maint) begin
        maintenance_interval_ff <= strb_merge(maintenance_interval_ff, pwdata, pstrb);
      end
      if (wr_life) begin
        fan_service_life_ff <= strb_merge(fan_service_life_ff, pwdata, pstrb);
      end
    end
  end

  // fan hours: any write clears, whatever the data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_hours_count_ff <= `RHC_RST_ZERO;
      fan_ms_ff          <= `RHC_RST_ZERO;
    end else if (wr_fan) begin
      fan_hours_count_ff <= `RHC_RST_ZERO;
      fan_ms_ff          <= `RHC_RST_ZERO;
    end else if (fan_hour) begin
      fan_hours_count_ff <= fan_hours_count_ff + 32'h0000_0001;
      fan_ms_ff          <= `RHC_RST_ZERO;
    end else if (tick_ms) begin
      fan_ms_ff <= fan_ms_ff + 32'h0000_0001;
    end
  end

  // ****************************************
  // fault and alarm
  // ****************************************
  wire maint_hit = (maintenance_interval_ff != `RHC_RST_ZERO) &
                   (mot_sel >= maintenance_interval_ff);
  // unsigned compare avoids underflow when life is under the margin
  wire fan_hit   = (fan_service_life_ff != `RHC_RST_ZERO) &
                   ({1'b0, fan_hours_count_ff} + {1'b0, `RHC_FAN_MARGIN_H} >=
                    {1'b0, fan_service_life_ff});

  // a clearing write is judged a cycle late, against what it wrote; set wins
  reg  maint_clr_ff;
  reg  fan_clr_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_clr_ff          <= 1'b0;
      fan_clr_ff            <= 1'b0;
      maintenance_due_fault <= 1'b0;
      fan_life_alarm        <= 1'b0;
    end else begin
      maint_clr_ff <= wr_maint | wr_mot | wr_motb;
      fan_clr_ff   <= wr_fan | wr_life;
      if (maint_hit) begin
        maintenance_due_fault <= 1'b1;
      end else if (maint_clr_ff) begin
        maintenance_due_fault <= 1'b0;
      end
      if (fan_hit) begin
        fan_life_alarm <= 1'b1;
      end else if (fan_clr_ff) begin
        fan_life_alarm <= 1'b0;
      end
    end
  end

  // ****************************************
  // non-volatile save requests
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_save_total   <= 1'b0;
      nv_save_motor   <= 1'b0;
      nv_tot_ms_out   <= `RHC_RST_ZERO;
      nv_tot_days_out <= `RHC_RST_ZERO;
      nv_mot_out      <= `RHC_RST_ZERO;
    end else begin
      nv_save_total <= pf_rise;
      nv_save_motor <= pen_fall | pf_rise;
      if (pf_rise) begin
        nv_tot_ms_out   <= total_runtime_count_ff;
        nv_tot_days_out <= total_days_ff;
      end
      if (pen_fall | pf_rise) begin
        nv_mot_out <= mot_sel;
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = `RHC_RST_ZERO;
    case (paddr)
      `RHC_OFF_CTRL:        rd_mux = {31'h0, dset_b};
      `RHC_OFF_STATUS:      rd_mux = {28'h000_0000, nv_save_total, pen_s,
                                      fan_life_alarm, maintenance_due_fault};
      `RHC_OFF_TOT_MS:      rd_mux = total_runtime_count_ff;
      `RHC_OFF_TOT_DAYS:    rd_mux = total_days_ff;
      `RHC_OFF_REL_MS:      rd_mux = relative_runtime_count_ff;
      `RHC_OFF_MOT_HOURS:   rd_mux = motor_hours_count_ff;
      `RHC_OFF_MAINT_INT:   rd_mux = maintenance_interval_ff;
      `RHC_OFF_FAN_HOURS:   rd_mux = fan_hours_count_ff;
      `RHC_OFF_FAN_LIFE:    rd_mux = fan_service_life_ff;
      `RHC_OFF_MOT_HOURS_B: rd_mux = motor_hours_b_ff;
      default:              rd_mux = `RHC_RST_ZERO;
    endcase
  end

  // taken in the setup phase so prdata is a flip-flop with no wait state;
  // a counter read this way is one cycle old
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RHC_RST_ZERO;
    end else if (psel & ~penable) begin
      prdata <= rd_mux;
    end
  end

endmodule // rhc_runtime

// [rhc_runtime_checker.sv]
/*
 port assertions for the runtime hours counter block.
 assumes it is bound to rhc_runtime and sees only its ports.
*/
`timescale 1ns/1ps
module rhc_runtime_checker #(
  parameter integer TICK_CYCLES = 200000
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        pulse_en,
  input wire        power_fail,
  input wire        nv_save_total,
  input wire        nv_save_motor,
  input wire        maintenance_due_fault,
  input wire        fan_life_alarm
);
  wire acc;
  wire wr;
  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // assertions
  // ****************
  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && paddr > 12'h024 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= 12'h024 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_save_on_fail: assert property ($rose(power_fail) |-> ##[2:6] nv_save_total)
    else $error("no total save after power fail");
  a_save_only_fail: assert property (!power_fail [*8] |-> !nv_save_total)
    else $error("total save without power fail");
  a_save_one_cycle: assert property (nv_save_total |=> !nv_save_total)
    else $error("total save pulse too long");
  a_motor_save_fall: assert property ($fell(pulse_en) |-> ##[2:6] nv_save_motor)
    else $error("no motor save after pulse enable fall");
  a_fault_hold: assert property ($fell(maintenance_due_fault) |-> $past(wr) || $past(wr, 2))
    else $error("fault dropped without a write");
  a_alarm_hold: assert property ($fell(fan_life_alarm) |-> $past(wr) || $past(wr, 2))
    else $error("alarm dropped without a write");
  c_fault: cover property ($rose(maintenance_due_fault));
  c_alarm: cover property ($rose(fan_life_alarm));
  c_save: cover property (nv_save_total);
  c_err: cover property (acc && pslverr);
endmodule // rhc_runtime_checker

bind rhc_runtime rhc_runtime_checker #(.TICK_CYCLES(TICK_CYCLES)) i_rhc_runtime_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata,
  .pulse_en, .power_fail, .nv_save_total, .nv_save_motor, .maintenance_due_fault,
  .fan_life_alarm);

// [tb.sv]
/*
 self-checking bench for the runtime hours counter block.
 assumes a 4-cycle tick so that millisecond counts run fast.
*/
`timescale 1ns/1ps
`include "rhc_consts.vh"
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, r0;
  logic        pulse_en, power_fail, nv_restore, s_tot, s_mot, fault, alarm;
  logic [31:0] ms_in, days_in, tot_ms_o, tot_days_o, mot_o;
  int          n_mismatch, samples_checked;
  rhc_runtime #(.TICK_CYCLES(4)) i_rhc_runtime (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready,
    .pslverr, .prdata, .pulse_en, .power_fail, .nv_restore, .nv_tot_ms_in(ms_in),
    .nv_tot_days_in(days_in), .nv_mot_a_in(32'h0000_0003), .nv_mot_b_in(32'h0000_0004),
    .nv_save_total(s_tot), .nv_save_motor(s_mot), .nv_tot_ms_out(tot_ms_o),
    .nv_tot_days_out(tot_days_o), .nv_mot_out(mot_o), .maintenance_due_fault(fault),
    .fan_life_alarm(alarm));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ****************
  // bus and helpers
  // ****************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    `CHK("pslverr", a > 12'h024, pslverr)
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_and_unmapped();
    rd("ctrl", `RHC_OFF_CTRL, 32'h0);
    rd("mot_hours", `RHC_OFF_MOT_HOURS, 32'h0);
    rd("maint_int", `RHC_OFF_MAINT_INT, 32'h0);
    rd("fan_life", `RHC_OFF_FAN_LIFE, 32'h0);
    rd("unmapped", 12'h040, 32'h0);
  endtask
  task automatic t_total_wrap();
    apb(1'b1, `RHC_OFF_TOT_MS, 32'h0526_5BFD);
    waitc(40);
    rd("tot_days", `RHC_OFF_TOT_DAYS, 32'h0000_0001);
    apb(1'b0, `RHC_OFF_TOT_MS, 32'h0);
    `CHK("tot_ms_wrapped", 1'b1, rdat < 32'd16)
  endtask
  task automatic t_relative();
    apb(1'b0, `RHC_OFF_REL_MS, 32'h0);
    r0 = rdat;
    waitc(40);
    apb(1'b0, `RHC_OFF_REL_MS, 32'h0);
    `CHK("rel_ms_delta", 1'b1, (rdat - r0) >= 10 && (rdat - r0) <= 12)
  endtask
  task automatic t_power_save();
    apb(1'b0, `RHC_OFF_TOT_MS, 32'h0);
    r0 = rdat;
    power_fail <= 1'b1;
    for (int k = 0; k < 12 && s_tot !== 1'b1; k++) @(posedge pclk);
    `CHK("save_total", 1'b1, s_tot)
    @(posedge pclk);
    `CHK("saved_days", 32'h0000_0001, tot_days_o)
    `CHK("saved_ms", 1'b1, (tot_ms_o - r0) <= 32'd3)
    power_fail <= 1'b0;
  endtask
  task automatic t_restore();
    ms_in <= 32'd100; days_in <= 32'd7; nv_restore <= 1'b1;
    waitc(4);
    nv_restore <= 1'b0;
    waitc(1);
    rd("days_restored", `RHC_OFF_TOT_DAYS, 32'd7);
    apb(1'b0, `RHC_OFF_TOT_MS, 32'h0);
    `CHK("ms_restored", 1'b1, rdat >= 100 && rdat <= 110)
    days_in <= 32'd9;
    apb(1'b1, `RHC_OFF_CTRL, 32'h0000_0002);
    waitc(4);
    rd("days_sw_restore", `RHC_OFF_TOT_DAYS, 32'd9);
  endtask
  task automatic t_motor();
    apb(1'b1, `RHC_OFF_MOT_HOURS, 32'd5);
    waitc(3);
    `CHK("fault_int_zero", 1'b0, fault)
    apb(1'b1, `RHC_OFF_MAINT_INT, 32'd5);
    waitc(20);
    `CHK("fault_due", 1'b1, fault)
    apb(1'b1, `RHC_OFF_MAINT_INT, 32'd6);
    waitc(2);
    `CHK("fault_rearmed", 1'b0, fault)
    pulse_en <= 1'b1;
    waitc(6);
    apb(1'b0, `RHC_OFF_STATUS, 32'h0);
    `CHK("pulse_seen", 1'b1, rdat[`RHC_ST_PULSE_BIT])
    pulse_en <= 1'b0;
    for (int k = 0; k < 12 && s_mot !== 1'b1; k++) @(posedge pclk);
    @(posedge pclk);
    `CHK("saved_motor", 32'd5, mot_o)
    apb(1'b1, `RHC_OFF_MOT_HOURS_B, 32'd7);
    apb(1'b0, `RHC_OFF_MOT_HOURS, 32'h0);
    r0 = rdat;
    apb(1'b0, `RHC_OFF_MOT_HOURS_B, 32'h0);
    `CHK("hours_sum", 32'd12, r0 + rdat)
    apb(1'b1, `RHC_OFF_CTRL, 32'h0000_0001);
    rd("ctrl_set_b", `RHC_OFF_CTRL, 32'h0000_0001);
    `CHK("fault_set_b", 1'b1, fault)
  endtask
  task automatic t_fan();
    apb(1'b1, `RHC_OFF_FAN_HOURS, 32'h0000_1234);
    rd("fan_cleared", `RHC_OFF_FAN_HOURS, 32'h0);
    apb(1'b1, `RHC_OFF_FAN_LIFE, 32'd500);
    waitc(2);
    `CHK("alarm_margin", 1'b1, alarm)
    apb(1'b1, `RHC_OFF_FAN_LIFE, 32'd501);
    waitc(2);
    `CHK("alarm_outside", 1'b0, alarm)
    apb(1'b1, `RHC_OFF_FAN_LIFE, 32'd500);
    apb(1'b1, `RHC_OFF_FAN_LIFE, 32'd0);
    waitc(2);
    `CHK("alarm_life_zero", 1'b0, alarm)
  endtask
  // ****************
  // run control
  // ****************
  task automatic final_report();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pulse_en = 1'b0; power_fail = 1'b0; nv_restore = 1'b0;
    ms_in = 32'h0; days_in = 32'h0; n_mismatch = 0; samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_and_unmapped();
    t_total_wrap();
    t_relative();
    t_power_save();
    t_restore();
    t_motor();
    t_fan();
    final_report();
  end
  initial begin
    // the whole run is well under 2000 cycles
    #(5 * 20000);
    n_mismatch++;
    final_report();
  end
endmodule // tb
